// ---- logic/mia_arb_if.sv ----
// signals between the register core and the priority arbiter.
// assumes both ends sit on the same clock.
`timescale 1ns/1ns
`default_nettype none

interface mia_arb_if;
  logic [12:0]         pending;
  logic [12:0]         high;
  logic                req;
  logic [3:0]          slot;
  mia_pkg::mia_level_t level;

  modport arb (input pending, input high, output req, output slot, output level);
  modport ctl (output pending, output high, input req, input slot, input level);
endinterface

`default_nettype wire

// ---- logic/mia_arbiter.sv ----
// picks the winning interrupt slot: power fail, then high, then low,
// lower natural priority number first inside a level.
// assumes pending already gated by enables.
`timescale 1ns/1ns
`default_nettype none

module mia_arbiter (
  mia_arb_if.arb a
);
  always_comb begin
    a.req   = 1'b0;
    a.slot  = 4'h0;
    a.level = mia_pkg::LVL_NONE;
    if (a.pending[0]) begin
      a.req   = 1'b1;
      a.level = mia_pkg::LVL_PFI;
    end else begin
      for (int i = 12; i >= 1; i--) begin
        if (a.pending[i] && !a.high[i]) begin
          a.req   = 1'b1;
          a.slot  = 4'(i);
          a.level = mia_pkg::LVL_LOW;
        end
      end
      for (int i = 12; i >= 1; i--) begin
        if (a.pending[i] && a.high[i]) begin
          a.req   = 1'b1;
          a.slot  = 4'(i);
          a.level = mia_pkg::LVL_HIGH;
        end
      end
    end
  end
endmodule

`default_nettype wire

// ---- logic/mia_pkg.sv ----
// constants of the core interrupt aggregator: register map, bit positions,
// reset values and the fixed vector table.
// assumes an 8-bit register port with 16-bit addresses.
`default_nettype none

package mia_pkg;

  // ********************************
  // register map
  // ********************************
  localparam logic [15:0] OFS_SRC   = 16'h7f00;
  localparam logic [15:0] OFS_MASK  = 16'h7f01;
  localparam logic [15:0] OFS_CFG0  = 16'h7ff4;
  localparam logic [15:0] OFS_TCTL  = 16'h7f80;
  localparam logic [15:0] OFS_IEN   = 16'h7f81;
  localparam logic [15:0] OFS_IPRI  = 16'h7f82;
  localparam logic [15:0] OFS_EICTL = 16'h7f83;
  localparam logic [15:0] OFS_EFLG  = 16'h7f84;
  localparam logic [15:0] OFS_EIEN  = 16'h7f85;
  localparam logic [15:0] OFS_EIPRI = 16'h7f86;
  localparam logic [7:0]  RST_BYTE  = 8'h00;

  // ********************************
  // bit positions
  // ********************************
  localparam int CFG_SEL_BIT  = 4;
  localparam int TC_IE0_BIT   = 1;
  localparam int TC_IE1_BIT   = 3;
  localparam int TC_TF0_BIT   = 5;
  localparam int TC_TF1_BIT   = 7;
  localparam int EI_RES_BIT   = 3;
  localparam int EI_PFI_FLAG  = 4;
  localparam int EI_PFI_EN    = 5;
  localparam int EF_FLAG_LO   = 4;
  localparam int EF_WAKE_BIT  = 7;
  localparam int IE_ALL_BIT   = 7;
  localparam int EIE_WAKE_BIT = 3;

  // ********************************
  // interrupt slots, index = natural priority
  // ********************************
  localparam int NUM_SLOTS = 13;
  localparam logic [7:0] VEC [0:12] = '{8'h33, 8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b,
                                        8'h3b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};

  typedef enum logic [1:0] {LVL_NONE, LVL_LOW, LVL_HIGH, LVL_PFI} mia_level_t;

endpackage

`default_nettype wire

// ---- logic/mia_sync.sv ----
// two-flop synchronisers with edge pulses for a group of pins.
// assumes asynchronous inputs; pulses are one clk cycle long.
`timescale 1ns/1ns
`default_nettype none

module mia_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         reset_n,
  input  wire logic [W-1:0] pin,
  output logic      [W-1:0] lvl,
  output logic      [W-1:0] rise,
  output logic      [W-1:0] edge_any
);
  logic [W-1:0] meta;
  logic [W-1:0] last;

  // meta feeds only lvl; edges compare lvl with last
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= '0;
      lvl  <= '0;
      last <= '0;
    end else begin
      meta <= pin;
      lvl  <= meta;
      last <= lvl;
    end
  end

  assign rise     = lvl & ~last;
  assign edge_any = lvl ^ last;
endmodule

`default_nettype wire

// ---- logic/mia_top.sv ----
// core interrupt aggregator: flag, enable and priority registers for the
// thirteen vector slots, and the external interrupt 0 source/mask pair.
// assumes a one-cycle register port on clk and asynchronous event pins.
//
// Behaviour
// - power fail: slot 0, vector 0x33, no priority
// - ext irq 0: slot 1, vector 0x03
// - timer0, ext irq1, timer1 at 0x0b/13/1b
// - serial 0x23, timer2 0x2b
// - ext irq 2..5 at 0x43..0x5b
// - ext irq 5 collects all wake events
// - wake edges detected per pin, any function
// - unmasked source bits ORed onto ext irq 0
// - source bits clear only on written one
// - bits 7,6 need port logic select
// - bits 5,4 muxed by port logic select
// - channel b keyboard pins, a mouse pins
// - bit 3 two-wire, bits 2..0 edge wakes
// - mask bit one masks its source
// - masked sources still show in source
// - source and mask reset to zero
// - three levels, power fail preempts all
`timescale 1ns/1ns
`default_nettype none

module mia_top (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [15:0] reg_addr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  input  wire logic        power_fail_pin,
  input  wire logic        ext_irq1_in,
  input  wire logic        ext_irq2_in,
  input  wire logic        ext_irq3_in,
  input  wire logic        ext_irq4_in,
  input  wire logic        wake_irq_in,
  input  wire logic        port_chan_d_irq,
  input  wire logic        port_chan_c_irq,
  input  wire logic        port_chan_b_irq,
  input  wire logic        port_chan_a_irq,
  input  wire logic        alt_port2_irq,
  input  wire logic        alt_port1_irq,
  input  wire logic        twowire2_irq,
  input  wire logic        wake_ee4_pin,
  input  wire logic        wake_ee2_pin,
  input  wire logic        wake_ee3_pin,
  input  wire logic        timer0_overflow,
  input  wire logic        timer1_overflow,
  input  wire logic        timer2_overflow,
  input  wire logic        timer2_ext_reload,
  input  wire logic        serial0_tx_done,
  input  wire logic        serial0_rx_done,
  input  wire logic        irq_ack,
  output logic             ext_irq0_in,
  output logic             irq_req,
  output logic      [7:0]  irq_vector,
  output logic      [1:0]  irq_level,
  output logic             core_wake
);

  // ********************************
  // event capture
  // ********************************
  // bit order: 14 pfi, 13..10 ext irq1..4, 9 wake, 8..5 chan d..a,
  // 4..3 alt p2/p1, 2 two-wire, 1..0 tied low and unused
  logic [14:0] ev_lvl;
  logic [14:0] ev_rise;
  logic [2:0]  wk_lvl;
  logic [2:0]  wk_edge;

  mia_sync #(.W(15)) u_ev_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin      ({power_fail_pin, ext_irq1_in, ext_irq2_in, ext_irq3_in, ext_irq4_in, wake_irq_in,
                port_chan_d_irq, port_chan_c_irq, port_chan_b_irq, port_chan_a_irq,
                alt_port2_irq, alt_port1_irq, twowire2_irq, 2'b00}),
    .lvl      (ev_lvl),
    .rise     (ev_rise),
    .edge_any ()
  );

  // wake pins are watched raw, whatever function the pin carries
  mia_sync #(.W(3)) u_wk_sync (
    .clk      (clk),
    .reset_n  (reset_n),
    .pin      ({wake_ee4_pin, wake_ee2_pin, wake_ee3_pin}),
    .lvl      (wk_lvl),
    .rise     (),
    .edge_any (wk_edge)
  );

  // ********************************
  // register decode
  // ********************************
  logic [7:0] src;
  logic [7:0] mask;
  logic [7:0] cfg0;
  logic [7:0] tctl;
  logic [7:0] ien;
  logic [7:0] ipri;
  logic [7:0] eictl;
  logic [7:0] eflg;
  logic [7:0] eien;
  logic [7:0] eipri;

  wire hit_src   = reg_addr == mia_pkg::OFS_SRC;
  wire hit_mask  = reg_addr == mia_pkg::OFS_MASK;
  wire hit_cfg0  = reg_addr == mia_pkg::OFS_CFG0;
  wire hit_tctl  = reg_addr == mia_pkg::OFS_TCTL;
  wire hit_ien   = reg_addr == mia_pkg::OFS_IEN;
  wire hit_ipri  = reg_addr == mia_pkg::OFS_IPRI;
  wire hit_eictl = reg_addr == mia_pkg::OFS_EICTL;
  wire hit_eflg  = reg_addr == mia_pkg::OFS_EFLG;
  wire hit_eien  = reg_addr == mia_pkg::OFS_EIEN;
  wire hit_eipri = reg_addr == mia_pkg::OFS_EIPRI;

  wire [7:0] rd_mux = hit_src   ? src   :
                      hit_mask  ? mask  :
                      hit_cfg0  ? cfg0  :
                      hit_tctl  ? tctl  :
                      hit_ien   ? ien   :
                      hit_ipri  ? ipri  :
                      hit_eictl ? eictl :
                      hit_eflg  ? eflg  :
                      hit_eien  ? eien  :
                      hit_eipri ? eipri : 8'h00;

  // ********************************
  // external interrupt 0 sources
  // ********************************
  wire port_logic_select = cfg0[mia_pkg::CFG_SEL_BIT];
  wire [7:0] src_set;
  assign src_set[7] = port_logic_select & ev_rise[8];
  assign src_set[6] = port_logic_select & ev_rise[7];
  // channel b is the keyboard port, channel a the external mouse port
  assign src_set[5] = port_logic_select ? ev_rise[6] : ev_rise[4];
  assign src_set[4] = port_logic_select ? ev_rise[5] : ev_rise[3];
  // level source: re-sets while the controller still asserts it
  assign src_set[3] = ev_lvl[2];
  assign src_set[2:0] = wk_edge;

  wire [7:0] src_clr = (reg_wr && hit_src) ? reg_wdata : 8'h00;
  wire [7:0] next_src = (src & ~src_clr) | src_set;
  wire next_irq0 = |(next_src & ~mask);

  // ********************************
  // flag registers
  // ********************************
  wire ack_int0 = irq_ack && irq_level != mia_pkg::LVL_PFI && irq_vector == mia_pkg::VEC[1];
  wire ack_int1 = irq_ack && irq_vector == mia_pkg::VEC[3];
  wire ack_tf0  = irq_ack && irq_vector == mia_pkg::VEC[2];
  wire ack_tf1  = irq_ack && irq_vector == mia_pkg::VEC[4];
  wire irq0_rise = next_irq0 & ~ext_irq0_in;

  wire [7:0] tctl_set = {timer1_overflow, 1'b0, timer0_overflow, 1'b0, ev_rise[13], 1'b0, irq0_rise, 1'b0};
  wire [7:0] tctl_ack = {ack_tf1, 1'b0, ack_tf0, 1'b0, ack_int1, 1'b0, ack_int0, 1'b0};
  wire [7:0] tctl_base = (reg_wr && hit_tctl) ? reg_wdata : tctl;
  wire [7:0] next_tctl = (tctl_base & ~tctl_ack) | tctl_set;

  // ext irq 5 gathers the wake pin and every edge wake event
  wire wake_any = ev_rise[9] | (|wk_edge);
  wire [7:0] eflg_set = {wake_any, ev_rise[10], ev_rise[11], ev_rise[12], 4'h0};
  wire [7:0] eflg_base = (reg_wr && hit_eflg) ? reg_wdata : eflg;
  wire [7:0] next_eflg = eflg_base | eflg_set;

  wire [7:0] eictl_base = (reg_wr && hit_eictl) ? reg_wdata : eictl;
  wire [7:0] next_eictl = eictl_base | ({7'h00, ev_rise[14]} << mia_pkg::EI_PFI_FLAG);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      src         <= mia_pkg::RST_BYTE;
      mask        <= mia_pkg::RST_BYTE;
      ext_irq0_in <= 1'b0;
      reg_rdata   <= 8'h00;
    end else begin
      src         <= next_src;
      mask        <= (reg_wr && hit_mask) ? reg_wdata : mask;
      ext_irq0_in <= next_irq0;
      reg_rdata   <= reg_rd ? rd_mux : 8'h00;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cfg0  <= mia_pkg::RST_BYTE;
      tctl  <= mia_pkg::RST_BYTE;
      ien   <= mia_pkg::RST_BYTE;
      ipri  <= mia_pkg::RST_BYTE;
      eictl <= mia_pkg::RST_BYTE;
      eflg  <= mia_pkg::RST_BYTE;
      eien  <= mia_pkg::RST_BYTE;
      eipri <= mia_pkg::RST_BYTE;
    end else begin
      cfg0  <= (reg_wr && hit_cfg0) ? reg_wdata : cfg0;
      tctl  <= next_tctl;
      ien   <= (reg_wr && hit_ien) ? reg_wdata : ien;
      ipri  <= (reg_wr && hit_ipri) ? reg_wdata : ipri;
      eictl <= next_eictl;
      eflg  <= next_eflg;
      eien  <= (reg_wr && hit_eien) ? reg_wdata : eien;
      eipri <= (reg_wr && hit_eipri) ? reg_wdata : eipri;
    end
  end

  // ********************************
  // slot pending, enable and priority
  // ********************************
  mia_arb_if arb_bus ();
  wire all_en = ien[mia_pkg::IE_ALL_BIT];
  wire [12:0] slot_flag = {eictl[mia_pkg::EI_RES_BIT], eflg[7:mia_pkg::EF_FLAG_LO],
                           1'b0,
                           timer2_overflow | timer2_ext_reload, serial0_tx_done | serial0_rx_done,
                           tctl[mia_pkg::TC_TF1_BIT], tctl[mia_pkg::TC_IE1_BIT],
                           tctl[mia_pkg::TC_TF0_BIT], tctl[mia_pkg::TC_IE0_BIT],
                           eictl[mia_pkg::EI_PFI_FLAG]};
  wire [12:0] slot_en = {eien[4:0], ien[6:0], eictl[mia_pkg::EI_PFI_EN]};
  // power fail has no priority bit, it always ranks above both levels
  assign arb_bus.pending = slot_flag & slot_en & {{12{all_en}}, 1'b1};
  assign arb_bus.high    = {eipri[4:0], ipri[6:0], 1'b0};

  mia_arbiter u_arb (
    .a (arb_bus.arb)
  );

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_req    <= 1'b0;
      irq_vector <= 8'h00;
      irq_level  <= 2'h0;
    end else begin
      irq_req    <= arb_bus.req;
      irq_vector <= mia_pkg::VEC[arb_bus.slot];
      irq_level  <= arb_bus.level;
    end
  end

  // the wake interrupt restarts a sleeping core even with the global enable off
  assign core_wake = eflg[mia_pkg::EF_WAKE_BIT] & eien[mia_pkg::EIE_WAKE_BIT];

  // ********************************
  // checks
  // ********************************
  logic seen_clk;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      seen_clk <= 1'b0;
    end else begin
      seen_clk <= 1'b1;
    end
  end

  sequence s_wake_event;
    $changed(wk_lvl[1]) || ev_rise[9];
  endsequence

  sequence s_wake_flagged;
    eflg[mia_pkg::EF_WAKE_BIT] [*2];
  endsequence

  a_reset_zero: assert property (@(posedge clk) disable iff (!reset_n)
    !seen_clk |-> src == 8'h00 && mask == 8'h00)
    else $error("source or mask not zero after reset");

  a_set_wins: assert property (@(posedge clk) disable iff (!reset_n)
    src_set != 8'h00 |=> (src & $past(src_set)) == $past(src_set))
    else $error("source event lost against clear");

  a_w1c_only: assert property (@(posedge clk) disable iff (!reset_n)
    reg_wr && hit_src && src_set == 8'h00 |=> src == ($past(src) & ~$past(reg_wdata)))
    else $error("source write did not clear exactly the written ones");

  a_or_unmasked: assert property (@(posedge clk) disable iff (!reset_n)
    (|(src & ~mask)) && !(reg_wr && (hit_src || hit_mask)) |=> ext_irq0_in)
    else $error("unmasked source did not raise ext irq 0");

  a_mask_blocks: assert property (@(posedge clk) disable iff (!reset_n)
    mask == 8'hff && !(reg_wr && hit_mask) ##1 src != 8'h00 |-> !ext_irq0_in)
    else $error("masked source reached ext irq 0");

  a_sel_gates_cd: assert property (@(posedge clk) disable iff (!reset_n)
    !port_logic_select && ev_rise[8] && !src[7] && !(reg_wr && hit_cfg0) |=> !src[7])
    else $error("channel d set source while port logic deselected");

  a_mux_alt: assert property (@(posedge clk) disable iff (!reset_n)
    !port_logic_select && ev_rise[4] |=> src[5])
    else $error("alternate port 2 did not set bit 5");

  a_wake_edges: assert property (@(posedge clk) disable iff (!reset_n)
    $changed(wk_lvl[0]) |=> src[0] ##0 eflg[mia_pkg::EF_WAKE_BIT])
    else $error("wake pin edge missed");

  a_wake_collect: assert property (@(posedge clk) disable iff (!reset_n)
    s_wake_event |=> s_wake_flagged or (eflg[mia_pkg::EF_WAKE_BIT] && reg_wr && hit_eflg))
    else $error("wake event not collected on ext irq 5");

  a_pulse_one: assert property (@(posedge clk) disable iff (!reset_n)
    ev_rise[13] |=> !ev_rise[13])
    else $error("event pulse longer than one cycle");

  a_pfi_first: assert property (@(posedge clk) disable iff (!reset_n)
    arb_bus.pending[0] |=> irq_req && irq_level == 2'h3 && irq_vector == 8'h33)
    else $error("power fail not granted first at 0x33");

  a_req_any: assert property (@(posedge clk) disable iff (!reset_n)
    (|arb_bus.pending) |=> irq_req)
    else $error("pending slot did not raise the request");

  a_int0_vec: assert property (@(posedge clk) disable iff (!reset_n)
    arb_bus.pending[1:0] == 2'b10 && arb_bus.high[1] |=> irq_vector == 8'h03)
    else $error("high ext irq 0 not vectored to 0x03");

  a_resv_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !arb_bus.pending[7] ##1 1'b1)
    else $error("reserved slot 7 pending");

endmodule

`default_nettype wire

// ---- sim/mia_partner.sv ----
// model of the far side: peripheral event pins and the core's acknowledge.
// assumes one clock; the bench commands it with one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none

module mia_partner (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic [14:0] ev_go,
  input  wire logic        ack_go,
  input  wire logic        irq_req,
  output logic      [14:0] pins,
  output logic             irq_ack
);
  // ********************************
  // event pins
  // ********************************
  logic [1:0] cnt [15];
  logic       armed;

  // held three cycles so the two-flop input stage always sees the level
  always_ff @(posedge clk or negedge reset_n) begin
    for (int i = 0; i < 15; i++) begin
      if (!reset_n) cnt[i] <= 2'h0;
      else if (ev_go[i]) cnt[i] <= 2'h3;
      else if (cnt[i] != 2'h0) cnt[i] <= cnt[i] - 2'h1;
    end
  end

  always_comb begin
    for (int i = 0; i < 15; i++) pins[i] = cnt[i] != 2'h0;
  end

  // ********************************
  // core acknowledge
  // ********************************
  // acks only when told, so flags otherwise stay pending for inspection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      armed   <= 1'b0;
      irq_ack <= 1'b0;
    end else begin
      irq_ack <= armed && irq_req;
      armed   <= (armed && !irq_req) || ack_go;
    end
  end
endmodule

`default_nettype wire

// ---- sim/testbench.sv ----
// self-checking bench of the core interrupt aggregator.
// assumes the partner model drives the event pins and the acknowledge.
`timescale 1ns/1ns
`default_nettype none

module testbench;
  typedef struct {logic [7:0] cfg; int ev; logic [7:0] src;} mia_row_t;
  logic clk, reset_n, reg_wr, reg_rd, ack_go, twowire2_irq, irq_ack, ext_irq0_in, irq_req, core_wake;
  logic t0, t1, t2, t2x, stx, srx;
  logic [15:0] reg_addr;
  logic [7:0]  reg_wdata, reg_rdata, irq_vector, d;
  logic [1:0]  irq_level;
  logic [14:0] ev_go, pins;
  int          n_fail, checks_done;
  mia_row_t    rows [12] = '{'{8'h10, 6, 8'h80}, '{8'h10, 7, 8'h40}, '{8'h10, 8, 8'h20}, '{8'h10, 9, 8'h10},
    '{8'h00, 10, 8'h20}, '{8'h00, 11, 8'h10}, '{8'h00, 6, 8'h00}, '{8'h00, 8, 8'h00}, '{8'h10, 10, 8'h00},
    '{8'h00, 12, 8'h04}, '{8'h10, 13, 8'h02}, '{8'h00, 14, 8'h01}};
  int          sl [11] = '{1, 2, 3, 4, 5, 6, 8, 9, 10, 11, 12};
  logic [7:0]  vx [11] = '{8'h03, 8'h0b, 8'h13, 8'h1b, 8'h23, 8'h2b, 8'h43, 8'h4b, 8'h53, 8'h5b, 8'h63};

  mia_top u_dut (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .power_fail_pin(pins[0]), .ext_irq1_in(pins[1]),
    .ext_irq2_in(pins[2]), .ext_irq3_in(pins[3]), .ext_irq4_in(pins[4]), .wake_irq_in(pins[5]),
    .port_chan_d_irq(pins[6]), .port_chan_c_irq(pins[7]), .port_chan_b_irq(pins[8]), .port_chan_a_irq(pins[9]),
    .alt_port2_irq(pins[10]), .alt_port1_irq(pins[11]), .twowire2_irq(twowire2_irq), .wake_ee4_pin(pins[12]),
    .wake_ee2_pin(pins[13]), .wake_ee3_pin(pins[14]), .timer0_overflow(t0), .timer1_overflow(t1),
    .timer2_overflow(t2), .timer2_ext_reload(t2x), .serial0_tx_done(stx), .serial0_rx_done(srx),
    .irq_ack(irq_ack), .ext_irq0_in(ext_irq0_in), .irq_req(irq_req), .irq_vector(irq_vector),
    .irq_level(irq_level), .core_wake(core_wake));

  mia_partner u_far (.clk(clk), .reset_n(reset_n), .ev_go(ev_go), .ack_go(ack_go), .irq_req(irq_req),
    .pins(pins), .irq_ack(irq_ack));

  // ********************************
  // tasks
  // ********************************
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(posedge clk); reg_wr <= 1'b1; reg_addr <= a; reg_wdata <= v;
    @(posedge clk); reg_wr <= 1'b0;
  endtask

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp);
    chk8({7'h00, got}, {7'h00, exp});
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, input logic [7:0] exp);
    @(posedge clk); reg_rd <= 1'b1; reg_addr <= a;
    @(posedge clk); reg_rd <= 1'b0;
    #1 chk8(reg_rdata, exp);
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task automatic fire(input int i);
    @(posedge clk); ev_go <= 15'h0001 << i;
    @(posedge clk); ev_go <= 15'h0000;
  endtask

  task automatic chk_irq(input logic [7:0] v, input logic [1:0] l);
    chk1(irq_req, 1'b1);
    chk8(irq_vector, v);
    chk8({6'h00, irq_level}, {6'h00, l});
  endtask

  task automatic trig(input int s);
    case (s)
      1: fire(11);
      3: fire(1);
      8: fire(2);
      9: fire(3);
      10: fire(4);
      11: fire(5);
      2: begin @(posedge clk); t0 <= 1'b1; @(posedge clk); t0 <= 1'b0; end
      4: begin @(posedge clk); t1 <= 1'b1; @(posedge clk); t1 <= 1'b0; end
      5: begin @(posedge clk); srx <= 1'b1; end
      6: begin @(posedge clk); t2x <= 1'b1; end
      default: wr(mia_pkg::OFS_EICTL, 8'h08);
    endcase
  endtask

  task automatic test_done();
    $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  // ********************************
  // clock, reset, watchdog
  // ********************************
  always #2 clk = ~clk;

  initial begin
    #200000;
    n_fail++;
    test_done();
  end

  // ********************************
  // main sequence
  // ********************************
  initial begin
    {clk, reset_n, reg_wr, reg_rd, ack_go, twowire2_irq, t0, t1, t2, t2x, stx, srx} = '0;
    {reg_addr, reg_wdata, ev_go, n_fail, checks_done} = '0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    rchk(mia_pkg::OFS_SRC, 8'h00);
    rchk(mia_pkg::OFS_MASK, 8'h00);
    rchk(16'h7f40, 8'h00);
    foreach (rows[i]) begin
      wr(mia_pkg::OFS_CFG0, rows[i].cfg);
      fire(rows[i].ev);
      idle(10);
      rchk(mia_pkg::OFS_SRC, rows[i].src);
      chk1(ext_irq0_in, rows[i].src != 8'h00);
      wr(mia_pkg::OFS_SRC, 8'hff);
      rchk(mia_pkg::OFS_SRC, 8'h00);
    end
    // a masked source still shows but stays off the core input
    wr(mia_pkg::OFS_CFG0, 8'h10);
    wr(mia_pkg::OFS_MASK, 8'hff);
    rchk(mia_pkg::OFS_MASK, 8'hff);
    fire(6);
    idle(10);
    rchk(mia_pkg::OFS_SRC, 8'h80);
    chk1(ext_irq0_in, 1'b0);
    wr(mia_pkg::OFS_MASK, 8'h7f);
    idle(3);
    chk1(ext_irq0_in, 1'b1);
    wr(mia_pkg::OFS_MASK, 8'h00);
    fire(7);
    idle(10);
    wr(mia_pkg::OFS_SRC, 8'h00);
    rchk(mia_pkg::OFS_SRC, 8'hc0);
    wr(mia_pkg::OFS_SRC, 8'h80);
    rchk(mia_pkg::OFS_SRC, 8'h40);
    wr(mia_pkg::OFS_SRC, 8'h40);
    // clear while the two-wire level is still active does not stick
    @(posedge clk); twowire2_irq <= 1'b1;
    idle(6);
    wr(mia_pkg::OFS_SRC, 8'h08);
    rchk(mia_pkg::OFS_SRC, 8'h08);
    @(posedge clk); twowire2_irq <= 1'b0;
    idle(6);
    wr(mia_pkg::OFS_SRC, 8'h08);
    rchk(mia_pkg::OFS_SRC, 8'h00);
    wr(mia_pkg::OFS_CFG0, 8'h00);
    // earlier source events left the ext irq 0 flag set
    wr(mia_pkg::OFS_TCTL, 8'h00);
    foreach (sl[i]) begin
      wr(mia_pkg::OFS_IEN, sl[i] < 8 ? 8'h80 | (8'h01 << (sl[i] - 1)) : 8'h80);
      wr(mia_pkg::OFS_EIEN, sl[i] >= 8 ? 8'h01 << (sl[i] - 8) : 8'h00);
      trig(sl[i]);
      idle(10);
      chk_irq(vx[i], 2'h1);
      @(posedge clk); {srx, t2x} <= 2'b00;
      wr(mia_pkg::OFS_TCTL, 8'h00);
      wr(mia_pkg::OFS_EFLG, 8'h00);
      wr(mia_pkg::OFS_EICTL, 8'h00);
      wr(mia_pkg::OFS_SRC, 8'hff);
      idle(4);
      chk1(irq_req, 1'b0);
    end
    wr(mia_pkg::OFS_IEN, 8'hc0);
    idle(4);
    chk1(irq_req, 1'b0);
    // the other half of each shared slot raises it too
    @(posedge clk); {stx, t2} <= 2'b11;
    wr(mia_pkg::OFS_IEN, 8'hb0);
    idle(2);
    chk_irq(8'h23, 2'h1);
    wr(mia_pkg::OFS_IEN, 8'ha0);
    idle(2);
    chk_irq(8'h2b, 2'h1);
    @(posedge clk); {stx, t2} <= 2'b00;
    // high level beats natural order, power fail beats a pending low slot
    wr(mia_pkg::OFS_IPRI, 8'h08);
    wr(mia_pkg::OFS_IEN, 8'h8a);
    @(posedge clk); {t0, t1} <= 2'b11;
    @(posedge clk); {t0, t1} <= 2'b00;
    idle(4);
    rchk(mia_pkg::OFS_TCTL, 8'ha0);
    chk_irq(8'h1b, 2'h2);
    @(posedge clk); ack_go <= 1'b1;
    @(posedge clk); ack_go <= 1'b0;
    idle(6);
    chk_irq(8'h0b, 2'h1);
    wr(mia_pkg::OFS_EICTL, 8'h20);
    fire(0);
    idle(10);
    rchk(mia_pkg::OFS_EICTL, 8'h30);
    chk_irq(8'h33, 2'h3);
    wr(mia_pkg::OFS_EICTL, 8'h00);
    wr(mia_pkg::OFS_TCTL, 8'h00);
    wr(mia_pkg::OFS_IEN, 8'h00);
    // wake edge counts whichever port logic is selected
    wr(mia_pkg::OFS_EIEN, 8'h08);
    for (int s = 0; s < 2; s++) begin
      wr(mia_pkg::OFS_CFG0, s == 0 ? 8'h00 : 8'h10);
      fire(13);
      idle(10);
      chk1(core_wake, 1'b1);
      rchk(mia_pkg::OFS_EFLG, 8'h80);
      wr(mia_pkg::OFS_EFLG, 8'h00);
      idle(3);
      chk1(core_wake, 1'b0);
    end
    // a lone high-level slot must still raise the request
    wr(mia_pkg::OFS_SRC, 8'hff);
    wr(mia_pkg::OFS_TCTL, 8'h00);
    wr(mia_pkg::OFS_IPRI, 8'h01);
    wr(mia_pkg::OFS_IEN, 8'h81);
    fire(9);
    idle(10);
    chk_irq(8'h03, 2'h2);
    test_done();
  end
endmodule

`default_nettype wire
